// >>> adcp_pkg.sv
// Package with register map, field layouts and timing constants of the converter datapath.
package adcp_pkg;
  localparam int CLK_MHZ = 125;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_STATUS = 8'h06;
  localparam logic [7:0] IDX_CONTROL = 8'h08;
  localparam logic [7:0] IDX_DATA_PORT = 8'h09;
  localparam logic [7:0] IDX_SLOPE = 8'h16;
  localparam logic [7:0] IDX_GAIN_LOW = 8'h17;
  localparam logic [7:0] IDX_GAIN_HIGH = 8'h18;
  localparam logic [7:0] IDX_VOFF = 8'h19;
  localparam logic [7:0] IDX_TOFF = 8'h1A;
  // Reset values.
  localparam logic [15:0] RST_SLOPE = 16'h005C;
  localparam logic [15:0] RST_GAIN_LOW = 16'h2000;
  localparam logic [15:0] RST_GAIN_HIGH = 16'h0800;
  localparam logic [15:0] RST_VOFF = 16'h0000;
  // Minus 273 degrees in eighths of a degree.
  localparam logic [15:0] RST_TOFF = 16'hF778;
  // Control register fields.
  localparam int CTL_INTERVAL_LSB = 10;
  localparam int CTL_IREF = 7;
  localparam int CTL_CONT = 6;
  localparam int CTL_ACQ_LSB = 0;
  // Status register fields.
  localparam int ST_LAST_LSB = 8;
  localparam int ST_ACTIVE = 6;
  localparam int ST_FLAG = 5;
  localparam int ST_CFGSEL = 4;
  localparam int ST_IDX_LSB = 0;
  // Flag interval codes and sample counts.
  localparam logic [1:0] IVL_EVERY = 2'h0;
  localparam logic [1:0] IVL_SEQ = 2'h1;
  localparam logic [1:0] IVL_12 = 2'h2;
  localparam logic [1:0] IVL_16 = 2'h3;
  localparam logic [3:0] CNT_LAST_12 = 4'hB;
  localparam logic [3:0] CNT_LAST_16 = 4'hF;
  // Channel codes above this one select temperature mode.
  localparam logic [2:0] CH_LAST_PAIR = 3'h5;
  localparam logic [14:0] SLOPE_ZERO_DELTA = 15'h007C;
  // One step of acquisition extension.
  localparam int ACQ_STEP_NS = 128;
  localparam int ACQ_STEP_CYC = (ACQ_STEP_NS * CLK_MHZ + 999) / 1000;
  typedef struct packed {
    logic diode_temperature_mode;
    logic scale_select;
    logic acquisition_extend_enable;
    logic result_left_align;
    logic differential_select;
    logic [2:0] input_channel_select;
  } adcp_slot_s;
  typedef struct packed {
    logic [5:0] pos_input;
    logic [5:0] neg_input;
    logic temp_internal;
    logic temp_diode;
  } adcp_route_s;
endpackage : adcp_pkg

// >>> adcp_datapath.sv
// Slot configuration, offset correction and result buffer of the converter.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Gain trim picked by scale bit with internal reference.
// - Extension bit inserts programmed extra acquisition time.
// - Left alignment: bits 15..3, low three zero.
// - Right alignment: bits 12..0, sign extended above.
// - Single-ended negatives reported without clamping.
// - Channel codes 0-5 pairs, 11x internal temperature.
// - Buffer reads by index, then index increments.
// - Buffers reset to zero, software writes ignored.
// - Results are signed 13-bit values, aligned.
// - Temperature LSB eighth degree, voltage LSB one.
// - Eight-bit slope trim, upper byte reads zero.
// - Diode result gets temperature offset added.
// - Voltage result gets voltage offset added.
// - Gain trim bit 15 ignored.
// - Codes 2000h/1000h/0800h give 1x/2x/4x scale.
// - Interval 3 flags every 16 conversions.
// - Select bit picks 16 buffers or 8 slots.
// - Slot writes only while conversion inactive.
module adcp_datapath
  import adcp_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register bus.
  input wire logic i_hsel,
  input wire logic [AW-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Converter side.
  input wire logic [2:0] i_conv_slot,
  input wire logic i_acq_start,
  input wire logic i_res_valid,
  input wire logic [12:0] i_res_raw,
  input wire logic [2:0] i_res_slot,
  input wire logic [3:0] i_res_addr,
  input wire logic i_seq_end,
  output adcp_route_s o_route,
  output logic [14:0] o_gain_trim,
  output logic [7:0] o_slope_trim,
  output logic o_acq_hold,
  output logic o_conv_active,
  output logic o_data_flag
);
  typedef enum logic [1:0] {ACQ_IDLE = 2'b01, ACQ_WAIT = 2'b10} adcp_acq_e;

  function automatic logic [15:0] adcp_align(input logic [12:0] v, input logic left);
    if (left) begin
      adcp_align = {v, 3'h0};
    end else begin
      adcp_align = {{3{v[12]}}, v};
    end
  endfunction : adcp_align

  adcp_slot_s slot [8];
  logic [15:0] buf_q [16];
  logic [15:0] slope, gain_low, gain_high, voff, toff;
  logic iref, cont;
  logic [1:0] interval;
  logic [3:0] acq_ext;
  logic active, flag, cfg_sel;
  logic [3:0] idx, last_addr, conv_cnt;
  logic dp;
  logic [7:0] dp_idx;
  logic dp_write;
  adcp_acq_e acq_st;
  logic [11:0] acq_cnt;

  // Bus decode.
  wire acc = i_hsel && i_htrans[1] && i_hready;
  wire wr = dp && dp_write;
  wire rd = dp && !dp_write;
  wire [15:0] wd = i_hwdata[15:0];
  wire hit_st = dp_idx == IDX_STATUS;
  wire hit_ctl = dp_idx == IDX_CONTROL;
  wire hit_port = dp_idx == IDX_DATA_PORT;
  wire port_acc = dp && hit_port;
  wire slot_wr = wr && hit_port && cfg_sel && !active;
  wire st_wr = wr && hit_st;
  wire ctl_wr = wr && hit_ctl && !active;
  wire start = st_wr && wd[ST_ACTIVE] && !active;
  wire [3:0] next_idx = cfg_sel ? {1'b0, idx[2:0] + 3'h1} : idx + 4'h1;
  wire [15:0] st_word = {4'h0, last_addr, 1'b0, active, flag, cfg_sel, idx};
  wire [15:0] ctl_word = {4'h0, interval, 2'h0, iref, cont, 2'h0, acq_ext};
  wire [15:0] port_word = cfg_sel ? {8'h00, slot[idx[2:0]]} : buf_q[idx];
  wire [15:0] rdata =
    hit_st ? st_word :
    hit_ctl ? ctl_word :
    hit_port ? port_word :
    (dp_idx == IDX_SLOPE) ? {8'h00, slope[7:0]} :
    (dp_idx == IDX_GAIN_LOW) ? gain_low :
    (dp_idx == IDX_GAIN_HIGH) ? gain_high :
    (dp_idx == IDX_VOFF) ? voff :
    (dp_idx == IDX_TOFF) ? toff : 16'h0000;

  // Result correction; the sum keeps 13 bits, so firmware must avoid offsets that overflow.
  adcp_slot_s rs;
  assign rs = slot[i_res_slot];
  wire r_temp = rs.diode_temperature_mode || (rs.input_channel_select > CH_LAST_PAIR);
  wire [15:0] r_ofs = r_temp ? toff : voff;
  wire [15:0] r_sum = {{3{i_res_raw[12]}}, i_res_raw} + r_ofs;
  wire [15:0] r_word = adcp_align(r_sum[12:0], rs.result_left_align);

  // Flag interval; the counter runs in every mode, not only continuous.
  wire cnt_wrap = (interval == IVL_12) ? (conv_cnt == CNT_LAST_12) : (conv_cnt == CNT_LAST_16);
  wire flag_set = active && (
    (interval == IVL_EVERY && i_res_valid) ||
    (interval == IVL_SEQ && i_seq_end) ||
    (interval[1] && i_res_valid && cnt_wrap));
  wire flag_clr = (st_wr && !wd[ST_FLAG]) || start;

  // Converter side decode of the slot under conversion.
  adcp_slot_s cs;
  assign cs = slot[i_conv_slot];
  wire c_temp = cs.input_channel_select > CH_LAST_PAIR;
  wire [5:0] c_pair = c_temp ? 6'h00 : 6'h01 << cs.input_channel_select;
  wire [15:0] c_gain = (iref && cs.scale_select) ? gain_high : gain_low;
  wire [11:0] acq_len = 12'(acq_ext * ACQ_STEP_CYC);
  wire acq_go = i_acq_start && cs.acquisition_extend_enable && acq_ext != 4'h0;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dp <= 1'b0;
      dp_idx <= 8'h00;
      dp_write <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
      o_hresp <= 1'b0;
    end else begin
      dp <= acc;
      o_hreadyout <= !acc;
      if (acc) begin
        dp_idx <= 8'(i_haddr[AW-1:2]);
        dp_write <= i_hwrite;
      end
      if (rd) begin
        o_hrdata <= {16'h0000, rdata};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      slope <= RST_SLOPE;
      gain_low <= RST_GAIN_LOW;
      gain_high <= RST_GAIN_HIGH;
      voff <= RST_VOFF;
      toff <= RST_TOFF;
    end else if (wr) begin
      if (dp_idx == IDX_SLOPE) begin
        slope <= {8'h00, wd[7:0]};
      end
      if (dp_idx == IDX_GAIN_LOW) begin
        gain_low <= wd;
      end
      if (dp_idx == IDX_GAIN_HIGH) begin
        gain_high <= wd;
      end
      if (dp_idx == IDX_VOFF) begin
        voff <= wd;
      end
      if (dp_idx == IDX_TOFF) begin
        toff <= wd;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      iref <= 1'b0;
      cont <= 1'b0;
      interval <= IVL_EVERY;
      acq_ext <= 4'h0;
    end else if (ctl_wr) begin
      iref <= wd[CTL_IREF];
      cont <= wd[CTL_CONT];
      interval <= wd[CTL_INTERVAL_LSB +: 2];
      acq_ext <= wd[CTL_ACQ_LSB +: 4];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      active <= 1'b0;
      cfg_sel <= 1'b0;
      idx <= 4'h0;
      flag <= 1'b0;
      last_addr <= 4'h0;
      conv_cnt <= 4'h0;
    end else begin
      if (st_wr) begin
        active <= wd[ST_ACTIVE];
        cfg_sel <= wd[ST_CFGSEL];
        idx <= wd[ST_IDX_LSB +: 4];
      end else begin
        if (i_seq_end && !cont) begin
          active <= 1'b0;
        end
        if (port_acc) begin
          idx <= next_idx;
        end
      end
      if (flag_set) begin
        flag <= 1'b1;
      end else if (flag_clr) begin
        flag <= 1'b0;
      end
      if (start) begin
        conv_cnt <= 4'h0;
      end else if (i_res_valid) begin
        conv_cnt <= cnt_wrap ? 4'h0 : conv_cnt + 4'h1;
      end
      if (i_res_valid) begin
        last_addr <= i_res_addr;
      end
    end
  end

  // Result buffers take only converter results, never bus writes.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 16; i++) begin
        buf_q[i] <= 16'h0000;
      end
    end else if (i_res_valid) begin
      buf_q[i_res_addr] <= r_word;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 8; i++) begin
        slot[i] <= '0;
      end
    end else if (slot_wr) begin
      slot[idx[2:0]] <= wd[7:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      acq_st <= ACQ_IDLE;
      acq_cnt <= 12'h000;
      o_acq_hold <= 1'b0;
    end else begin
      case (acq_st)
        ACQ_IDLE: begin
          if (acq_go) begin
            acq_st <= ACQ_WAIT;
            acq_cnt <= acq_len - 12'h001;
            o_acq_hold <= 1'b1;
          end
        end
        ACQ_WAIT: begin
          if (acq_cnt == 12'h000 || !active) begin
            acq_st <= ACQ_IDLE;
            o_acq_hold <= 1'b0;
          end else begin
            acq_cnt <= acq_cnt - 12'h001;
          end
        end
        default: begin
          acq_st <= ACQ_IDLE;
          o_acq_hold <= 1'b0;
        end
      endcase
    end
  end

  // Route and trim outputs are registered so the analog side sees clean levels.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_route <= '0;
      o_gain_trim <= 15'h0000;
      o_slope_trim <= 8'h00;
      o_conv_active <= 1'b0;
      o_data_flag <= 1'b0;
    end else begin
      o_route.pos_input <= c_pair;
      o_route.neg_input <= cs.differential_select ? c_pair : 6'h00;
      o_route.temp_internal <= c_temp;
      o_route.temp_diode <= cs.diode_temperature_mode && !c_temp;
      o_gain_trim <= c_gain[14:0];
      o_slope_trim <= slope[7:0];
      o_conv_active <= active;
      o_data_flag <= flag;
    end
  end

  a_hready_wait: assert property (@(posedge i_mclk) disable iff (i_rst)
    acc |=> !o_hreadyout ##1 o_hreadyout)
    else $error("bus answer not after one wait state");
  a_left_align_pad: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_res_valid && rs.result_left_align |=> buf_q[$past(i_res_addr)][2:0] == 3'h0)
    else $error("left aligned result low bits not zero");
  a_right_sign_ext: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_res_valid && !rs.result_left_align |=>
    buf_q[$past(i_res_addr)][15:13] == {3{buf_q[$past(i_res_addr)][12]}})
    else $error("right aligned result not sign extended");
  a_voltage_offset: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_res_valid && !r_temp && !rs.result_left_align |=>
    buf_q[$past(i_res_addr)][12:0] == 13'($past(i_res_raw) + $past(voff)))
    else $error("voltage offset not applied");
  a_index_wrap: assert property (@(posedge i_mclk) disable iff (i_rst)
    port_acc && !st_wr && !cfg_sel && idx == 4'hF |=> idx == 4'h0)
    else $error("buffer index did not wrap");
  a_slot_locked: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr && hit_port && active |=> slot[$past(idx[2:0])] == $past(slot[idx[2:0]]))
    else $error("slot written during conversion");
  a_gain_pick: assert property (@(posedge i_mclk) disable iff (i_rst)
    !iref |=> o_gain_trim == $past(gain_low[14:0]))
    else $error("low range trim not used without internal reference");
  a_flag_16: assert property (@(posedge i_mclk) disable iff (i_rst)
    active && interval == IVL_16 && i_res_valid && conv_cnt == CNT_LAST_16 |=> flag)
    else $error("flag not raised after sixteen conversions");
  a_acq_off: assert property (@(posedge i_mclk) disable iff (i_rst)
    acq_st == ACQ_IDLE && i_acq_start && !cs.acquisition_extend_enable |=> !o_acq_hold)
    else $error("extra acquisition inserted while disabled");
  a_slope_high_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    rd && dp_idx == IDX_SLOPE |=> o_hrdata[15:8] == 8'h00)
    else $error("slope trim upper byte not zero");
endmodule : adcp_datapath
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench of the converter configuration and result datapath.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import adcp_pkg::*;
();
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] conv_slot = 3'h0;
  logic acq_start = 1'b0;
  logic res_valid = 1'b0;
  logic [12:0] res_raw = 13'h0;
  logic [2:0] res_slot = 3'h0;
  logic [3:0] res_addr = 4'h0;
  logic seq_end = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  adcp_route_s route;
  adcp_route_s er;
  wire logic [14:0] gain;
  wire logic [7:0] slope;
  wire logic acq_hold;
  wire logic conv_act;
  wire logic dflag;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  logic [15:0] rd;
  logic [15:0] voff;
  logic [15:0] toff;
  logic [12:0] raw;
  logic [7:0] cfg [8];
  logic [15:0] expv [16];
  logic [15:0] rstv [5] = '{RST_SLOPE, RST_GAIN_LOW, RST_GAIN_HIGH, RST_VOFF, RST_TOFF};

  adcp_datapath u_adcp_datapath (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_conv_slot(conv_slot), .i_acq_start(acq_start), .i_res_valid(res_valid),
    .i_res_raw(res_raw), .i_res_slot(res_slot), .i_res_addr(res_addr), .i_seq_end(seq_end),
    .o_route(route), .o_gain_trim(gain), .o_slope_trim(slope), .o_acq_hold(acq_hold),
    .o_conv_active(conv_act), .o_data_flag(dflag)
  );

  always #4 i_mclk = ~i_mclk;

  task automatic finish_test;
    $display("Counts: errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // A hung handshake would otherwise stall the run forever.
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single word transfer; the wait length is taken from the slave's ready.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     output logic [15:0] rdv);
    hsel <= 1'b1;
    haddr <= {idx[5:0], 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {16'h0, wd};
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    rdv = hrdata[15:0];
  endtask : bus

  task automatic pulse_res(input logic [12:0] rv, input logic [3:0] a);
    res_valid <= 1'b1;
    res_raw <= rv;
    res_slot <= a[2:0];
    res_addr <= a;
    @(posedge i_mclk);
    res_valid <= 1'b0;
    @(posedge i_mclk);
  endtask : pulse_res

  function automatic logic [15:0] exp_res(input logic [12:0] rv, input logic [7:0] c);
    logic [12:0] s;
    s = rv + ((c[7] || c[2:1] == 2'h3) ? toff[12:0] : voff[12:0]);
    return c[4] ? {s, 3'h0} : {{3{s[12]}}, s};
  endfunction : exp_res

  function automatic adcp_route_s exp_route(input logic [7:0] c);
    adcp_route_s r;
    r = '0;
    r.temp_internal = (c[2:1] == 2'h3);
    r.temp_diode = c[7] && !r.temp_internal;
    r.pos_input = 6'h01 << c[2:0];
    r.neg_input = c[3] ? r.pos_input : 6'h00;
    return r;
  endfunction : exp_route

  initial begin
    void'($urandom(68270));
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, IDX_SLOPE + 8'(i), 16'h0, rd);
      chk(rd, rstv[i]);
    end
    bus(1'b1, IDX_SLOPE, 16'hFF6C, rd);
    bus(1'b0, IDX_SLOPE, 16'h0, rd);
    chk(rd, 16'h006C);
    chk(slope, 8'h6C);
    bus(1'b1, 8'h30, 16'hFFFF, rd);
    bus(1'b0, 8'h30, 16'h0, rd);
    chk(rd, 16'h0);
    chk(hresp, 1'b0);
    voff = 16'($urandom);
    toff = 16'($urandom);
    bus(1'b1, IDX_VOFF, voff, rd);
    bus(1'b1, IDX_TOFF, toff, rd);
    bus(1'b1, IDX_GAIN_LOW, 16'hA000, rd);
    bus(1'b1, IDX_GAIN_HIGH, 16'h1000, rd);
    for (int k = 0; k < 8; k++) begin
      cfg[k] = 8'($urandom);
    end
    cfg[0] = 8'h08;
    cfg[1] = 8'h61;
    cfg[2] = 8'h15;
    cfg[3] = 8'h8E;
    cfg[4] = 8'h93;
    bus(1'b1, IDX_STATUS, 16'h0010, rd);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, IDX_DATA_PORT, {8'h0, cfg[k]}, rd);
    end
    bus(1'b0, IDX_STATUS, 16'h0, rd);
    chk(rd, 16'h0010);
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, IDX_DATA_PORT, 16'h0, rd);
      chk(rd, {8'h0, cfg[k]});
    end
    // Second pass enables the internal reference, so the scale bit matters.
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, IDX_CONTROL, 16'h0C03 | (16'(r) << 7), rd);
      for (int k = 0; k < 8; k++) begin
        conv_slot <= 3'(k);
        repeat (2) @(posedge i_mclk);
        er = exp_route(cfg[k]);
        chk(gain, (r == 1 && cfg[k][6]) ? 15'h1000 : 15'h2000);
        if (cfg[k][7] || er.temp_internal) begin
          chk({route.temp_internal, route.temp_diode}, {er.temp_internal, er.temp_diode});
        end else begin
          chk(route, er);
        end
      end
    end
    // Slot and control writes during a conversion must be dropped.
    bus(1'b1, IDX_STATUS, 16'h0050, rd);
    bus(1'b1, IDX_DATA_PORT, 16'h00FF, rd);
    bus(1'b1, IDX_CONTROL, 16'h0000, rd);
    bus(1'b0, IDX_CONTROL, 16'h0, rd);
    chk(rd, 16'h0C83);
    bus(1'b1, IDX_STATUS, 16'h0040, rd);
    for (int k = 0; k < 2; k++) begin
      conv_slot <= 3'(k);
      acq_start <= 1'b1;
      @(posedge i_mclk);
      acq_start <= 1'b0;
      n = 0;
      repeat (80) begin
        @(posedge i_mclk);
        n += int'(acq_hold);
      end
      chk(n, k * 3 * ACQ_STEP_CYC);
    end
    for (int a = 0; a < 16; a++) begin
      raw = (a == 1) ? 13'h1FF0 : 13'($urandom);
      expv[a] = exp_res(raw, cfg[a % 8]);
      pulse_res(raw, 4'(a));
      @(posedge i_mclk);
      chk(dflag, a == 15);
    end
    chk(conv_act, 1'b1);
    seq_end <= 1'b1;
    @(posedge i_mclk);
    seq_end <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk(conv_act, 1'b0);
    // A buffer write must leave the stored result untouched.
    bus(1'b1, IDX_STATUS, 16'h0000, rd);
    bus(1'b1, IDX_DATA_PORT, 16'hFFFF, rd);
    bus(1'b1, IDX_STATUS, 16'h0000, rd);
    for (int a = 0; a < 16; a++) begin
      bus(1'b0, IDX_DATA_PORT, 16'h0, rd);
      chk(rd, expv[a]);
    end
    bus(1'b0, IDX_STATUS, 16'h0, rd);
    chk(rd, 16'h0F00);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    bus(1'b0, IDX_DATA_PORT, 16'h0, rd);
    chk(rd, 16'h0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
